/* File: clcd_consts.svh */
// Offsets, field positions, reset values and timing figures of the LCD instruction unit
`ifndef CLCD_CONSTS_SVH
`define CLCD_CONSTS_SVH

// APB register byte offsets
`define CLCD_OFF_INSTR      8'h00
`define CLCD_OFF_DATA       8'h04
`define CLCD_OFF_STATUS     8'h08

// Status word field positions
`define CLCD_ST_FLAGS_LSB   0
`define CLCD_ST_SELCG_BIT   8
`define CLCD_ST_BUSY_BIT    9
`define CLCD_ST_PEND_BIT    10
`define CLCD_ST_SHIFT_LSB   16
`define CLCD_ST_AC_LSB      24

// Instruction byte field positions
`define CLCD_ENTRY_INCR_BIT 1
`define CLCD_ENTRY_SHIFT_BIT 0
`define CLCD_DISP_ON_BIT    2
`define CLCD_DISP_CUR_BIT   1
`define CLCD_DISP_BLINK_BIT 0
`define CLCD_SHIFT_SC_BIT   3
`define CLCD_SHIFT_RL_BIT   2
`define CLCD_FUNC_DL_BIT    4
`define CLCD_FUNC_N_BIT     3
`define CLCD_FUNC_F_BIT     2

// Reset and power-on values of the mode flags, address counter and display shift
`define CLCD_RST_DISP_ON    1'b0
`define CLCD_RST_CURSOR_ON  1'b0
`define CLCD_RST_BLINK_ON   1'b0
`define CLCD_RST_INCR       1'b1
`define CLCD_RST_SHIFT_ON   1'b0
`define CLCD_RST_BUS8       1'b1
`define CLCD_RST_TWO_LINE   1'b0
`define CLCD_RST_FONT10     1'b0
`define CLCD_RST_AC         7'h00
`define CLCD_RST_SHIFT      7'h00

// Memory contents
`define CLCD_FILL_CODE      8'h20
`define CLCD_DD_DEPTH       128
`define CLCD_CG_DEPTH       64

// Timing figures, times in microseconds at the reference oscillator rate
`define CLCD_CLK_MHZ        100
`define CLCD_REF_OSC_KHZ    250
`define CLCD_T_EXEC_US      40
`define CLCD_T_CLEAR_US     1640
`define CLCD_T_POR_US       10000
`define CLCD_T_ADD_US       6

`endif

/* File: clcd_host.sv */
// Host model: bus master that drives the unit's register port
`timescale 1ns/1ps
module clcd_host (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [7:0]  o_paddr,
	output logic      [31:0] o_pwdata
);
	// Idle bus at time zero
	initial
	begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end

	// Hung wait ends the run
	task automatic stuck();
		tb.miscompares++;
		tb.end_sim();
	endtask : stuck

	// One transfer, held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge i_sys_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_sys_clk);
		o_penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (i_pready !== 1'b1 && n < 50);
		if (i_pready !== 1'b1)
			stuck();
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_pwdata <= ~d; // Released data no longer shows the value
	endtask : xfer

	// Poll the status word until busy clears before instructing
	task automatic wait_idle();
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do
		begin
			xfer(1'b0, 8'h08, 32'h0, r, e);
			n++;
		end
		while (r[9] !== 1'b0 && n < 3000);
		if (r[9] !== 1'b0)
			stuck();
	endtask : wait_idle
endmodule : clcd_host

/* File: clcd_mem.sv */
// Byte memory with registered read port
`timescale 1ns/1ps
module clcd_mem #(
	parameter int P_DEPTH = 128,
	parameter int P_AW    = 7
) (
	input  wire logic            i_sys_clk,
	input  wire logic            i_reset_n,
	input  wire logic            i_we,
	input  wire logic [P_AW-1:0] i_waddr,
	input  wire logic [7:0]      i_wdata,
	input  wire logic [P_AW-1:0] i_raddr,
	output logic      [7:0]      o_rdata
);
	logic [7:0] mem_reg [P_DEPTH];

	// Write port
	always_ff @(posedge i_sys_clk)
	begin
		if (i_we)
			mem_reg[i_waddr] <= i_wdata;
	end

	// Registered read port
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_rdata <= 8'h00;
		else
			o_rdata <= mem_reg[i_raddr];
	end
endmodule : clcd_mem

/* File: clcd_pkg.sv */
// Types shared by the LCD instruction unit
package clcd_pkg;

	// Mode flags kept by the unit
	typedef struct packed {
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic incr;
		logic shift_on;
		logic bus8;
		logic two_line;
		logic font10;
	} clcd_flags_s;

	// Unit sequencing states
	typedef enum logic [1:0] {
		ST_POR  = 2'b00,
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} clcd_state_e;

	// Decoded operations
	typedef enum logic [3:0] {
		OP_NONE    = 4'h0,
		OP_CLEAR   = 4'h1,
		OP_HOME    = 4'h2,
		OP_ENTRY   = 4'h3,
		OP_DISPCTL = 4'h4,
		OP_SHIFT   = 4'h5,
		OP_FUNC    = 4'h6,
		OP_SET_CG  = 4'h7,
		OP_SET_DD  = 4'h8,
		OP_DWRITE  = 4'h9,
		OP_DREAD   = 4'hA
	} clcd_op_e;

endpackage : clcd_pkg

/* File: clcd_timer.sv */
// Down counter that times one execution and pulses when it runs out
`timescale 1ns/1ps
module clcd_timer #(
	parameter int P_W = 21
) (
	input  wire logic           i_sys_clk,
	input  wire logic           i_reset_n,
	input  wire logic           i_load,
	input  wire logic [P_W-1:0] i_count,
	output logic                o_busy,
	output logic                o_done
);
	logic [P_W-1:0] cnt_reg;

	// Load overrides counting; a load of zero cancels
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			cnt_reg <= '0;
		else if (i_load)
			cnt_reg <= i_count;
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - P_W'(1);
	end

	// One-cycle pulse when the count expires
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_done <= 1'b0;
		else
			o_done <= !i_load && (cnt_reg == P_W'(1));
	end

	assign o_busy = (cnt_reg != '0);
endmodule : clcd_timer

/* File: clcd_unit.sv */
// Instruction interpreter and power-on initializer of a character LCD controller
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "clcd_consts.svh"
module clcd_unit #(
	parameter int P_OSC_KHZ   = `CLCD_REF_OSC_KHZ,
	parameter int P_CLEAR_CYC = `CLCD_T_CLEAR_US * `CLCD_CLK_MHZ * `CLCD_REF_OSC_KHZ / P_OSC_KHZ,
	parameter int P_POR_CYC   = `CLCD_T_POR_US * `CLCD_CLK_MHZ
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_reset_n,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [7:0]          i_paddr,
	input  wire logic [31:0]         i_pwdata,
	output logic      [31:0]         o_prdata,
	output logic                     o_pready,
	output logic                     o_pslverr,
	output logic                     o_busy,
	output logic      [6:0]          o_addr_counter,
	output logic      [6:0]          o_disp_shift,
	output logic                     o_sel_glyph,
	output clcd_pkg::clcd_flags_s    o_flags
);
	import clcd_pkg::*;

	localparam int TW       = 21;
	localparam int EXEC_INT = `CLCD_T_EXEC_US * `CLCD_CLK_MHZ * `CLCD_REF_OSC_KHZ / P_OSC_KHZ;
	localparam int ADD_INT  = `CLCD_T_ADD_US * `CLCD_CLK_MHZ * `CLCD_REF_OSC_KHZ / P_OSC_KHZ;
	localparam logic [TW-1:0] EXEC_CYC  = TW'((EXEC_INT < 1) ? 1 : EXEC_INT);
	localparam logic [TW-1:0] ADD_CYC   = TW'((ADD_INT < 1) ? 1 : ADD_INT);
	localparam logic [TW-1:0] CLEAR_CYC = TW'((P_CLEAR_CYC < 1) ? 1 : P_CLEAR_CYC);
	localparam logic [TW-1:0] POR_CYC   = TW'((P_POR_CYC < 1) ? 1 : P_POR_CYC);

	// Opcode from the highest set bit; lower don't-care bits are ignored
	function automatic clcd_op_e decode_instr(input logic [7:0] b);
		clcd_op_e op;
		op = OP_NONE;
		casez (b)
			8'b1???????: op = OP_SET_DD;
			8'b01??????: op = OP_SET_CG;
			8'b001?????: op = OP_FUNC;
			8'b0001????: op = OP_SHIFT;
			8'b00001???: op = OP_DISPCTL;
			8'b000001??: op = OP_ENTRY;
			8'b0000001?: op = OP_HOME;
			8'b00000001: op = OP_CLEAR;
			default:     op = OP_NONE;
		endcase
		return op;
	endfunction : decode_instr

	// Next counter value for one step in the direction given by up
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
		input logic cg);
		logic [6:0] n;
		n = up ? a + 7'h01 : a - 7'h01;
		return cg ? {1'b0, n[5:0]} : n;
	endfunction : step_addr

	clcd_state_e state_reg;
	clcd_state_e state_next;
	clcd_flags_s flags_reg;
	clcd_op_e    op_reg;
	logic [7:0]  cmd_reg;
	logic [6:0]  ac_reg;
	logic [6:0]  shift_reg;
	logic        sel_cg_reg;
	logic        busy_reg;
	logic        nib_phase_reg;
	logic [3:0]  nib_hi_reg;
	logic        por_start_reg;
	logic        step_pend_reg;
	logic [7:0]  fill_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic [31:0] prdata_reg;

	logic        setup;
	logic        take;
	logic        acc;
	logic        is_instr;
	logic        is_data;
	logic        is_status;
	logic        err;
	logic        byte_done;
	logic [7:0]  host_byte;
	logic        instr_go;
	logic        dwr_go;
	logic        drd_go;
	logic        any_go;
	logic        tmr_load;
	logic [TW-1:0] tmr_count;
	logic        tmr_done;
	logic        exec_done;
	logic        por_done;
	logic        step_done;
	logic        step_apply;
	logic        step_load;
	logic [TW-1:0] step_count;
	logic        fill_active;
	logic        dd_we;
	logic [6:0]  dd_waddr;
	logic [7:0]  dd_wdata;
	logic        cg_we;
	logic [7:0]  dd_rdata;
	logic [7:0]  cg_rdata;
	logic [7:0]  rd_byte;
	logic [7:0]  rd_lane;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	// APB phase and address decode
	assign setup     = i_psel && !i_penable;
	assign take      = i_psel && i_penable && pready_reg;
	assign is_instr  = (i_paddr == `CLCD_OFF_INSTR);
	assign is_data   = (i_paddr == `CLCD_OFF_DATA);
	assign is_status = (i_paddr == `CLCD_OFF_STATUS);
	assign err = !(is_instr || is_data || is_status) || (is_status && i_pwrite)
		|| (busy_reg && ((is_instr && i_pwrite) || is_data));
	assign acc = take && !pslverr_reg;

	// Byte assembly from one 8-bit or two upper-nibble transfers
	assign byte_done = flags_reg.bus8 || nib_phase_reg;
	assign host_byte = flags_reg.bus8 ? i_pwdata[7:0] : {nib_hi_reg, i_pwdata[7:4]};
	assign instr_go  = acc && is_instr && i_pwrite && byte_done;
	assign dwr_go    = acc && is_data && i_pwrite && byte_done;
	assign drd_go    = acc && is_data && !i_pwrite && byte_done;
	assign any_go    = instr_go || dwr_go || drd_go;

	// Nibble phase and held high nibble
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			nib_phase_reg <= 1'b0;
			nib_hi_reg    <= 4'h0;
		end
		else if (exec_done && op_reg == OP_FUNC)
			nib_phase_reg <= 1'b0;
		else if (acc && (is_instr || is_data) && !flags_reg.bus8)
		begin
			nib_phase_reg <= !nib_phase_reg;
			if (!nib_phase_reg)
				nib_hi_reg <= i_pwdata[7:4];
		end
	end

	// Latch the received byte and its operation before executing
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cmd_reg <= 8'h00;
			op_reg  <= OP_NONE;
		end
		else if (instr_go)
		begin
			cmd_reg <= host_byte;
			op_reg  <= decode_instr(host_byte);
		end
		else if (dwr_go)
		begin
			cmd_reg <= host_byte;
			op_reg  <= OP_DWRITE;
		end
		else if (drd_go)
			op_reg <= OP_DREAD;
	end

	// Power-on start pulse taken just after reset release
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			por_start_reg <= 1'b1;
		else
			por_start_reg <= 1'b0;
	end

	// Execution timer; long operations take the clear time
	assign tmr_load  = por_start_reg || any_go;
	assign tmr_count = por_start_reg ? POR_CYC
		: (instr_go && (decode_instr(host_byte) == OP_CLEAR
		|| decode_instr(host_byte) == OP_HOME)) ? CLEAR_CYC
		: EXEC_CYC;
	assign exec_done = tmr_done && state_reg == ST_EXEC;
	assign por_done  = tmr_done && state_reg == ST_POR;

	clcd_timer #(.P_W(TW)) u_exec_tmr (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_load    (tmr_load),
		.i_count   (tmr_count),
		.o_busy    (),
		.o_done    (tmr_done)
	);

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_POR:  if (por_done) state_next = ST_IDLE;
			ST_IDLE: if (any_go) state_next = ST_EXEC;
			ST_EXEC: if (exec_done) state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State and busy flag
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_POR;
			busy_reg  <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			busy_reg  <= (state_next != ST_IDLE);
		end
	end

	// Delayed counter step after a data access
	assign step_load  = (exec_done && (op_reg == OP_DWRITE || op_reg == OP_DREAD))
		|| (any_go && step_pend_reg);
	assign step_count = any_go ? '0 : ADD_CYC;
	assign step_apply = step_pend_reg && (step_done || any_go);

	clcd_timer #(.P_W(TW)) u_step_tmr (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_load    (step_load),
		.i_count   (step_count),
		.o_busy    (),
		.o_done    (step_done)
	);

	// Pending step marker
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			step_pend_reg <= 1'b0;
		else if (exec_done && (op_reg == OP_DWRITE || op_reg == OP_DREAD))
			step_pend_reg <= 1'b1;
		else if (step_apply)
			step_pend_reg <= 1'b0;
	end

	// Address counter; changes only at execution end or step, so status shows the old value
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ac_reg <= `CLCD_RST_AC;
		else if (por_done)
			ac_reg <= `CLCD_RST_AC;
		else if (step_apply)
			ac_reg <= step_addr(ac_reg, flags_reg.incr, sel_cg_reg);
		else if (exec_done)
		begin
			unique case (op_reg)
				OP_CLEAR:  ac_reg <= 7'h00;
				OP_HOME:   ac_reg <= 7'h00;
				OP_SHIFT:  if (!cmd_reg[`CLCD_SHIFT_SC_BIT])
					ac_reg <= step_addr(ac_reg, cmd_reg[`CLCD_SHIFT_RL_BIT], 1'b0);
				OP_SET_CG: ac_reg <= {1'b0, cmd_reg[5:0]};
				OP_SET_DD: ac_reg <= cmd_reg[6:0];
				default:   ac_reg <= ac_reg;
			endcase
		end
	end

	// Display shift offset; positive counts are left shifts
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			shift_reg <= `CLCD_RST_SHIFT;
		else if (por_done)
			shift_reg <= `CLCD_RST_SHIFT;
		else if (exec_done)
		begin
			unique case (op_reg)
				OP_CLEAR:  shift_reg <= 7'h00;
				OP_HOME:   shift_reg <= 7'h00;
				OP_SHIFT:  if (cmd_reg[`CLCD_SHIFT_SC_BIT])
					shift_reg <= cmd_reg[`CLCD_SHIFT_RL_BIT] ? shift_reg - 7'h01
						: shift_reg + 7'h01;
				OP_DWRITE: if (flags_reg.shift_on && !sel_cg_reg)
					shift_reg <= flags_reg.incr ? shift_reg + 7'h01
						: shift_reg - 7'h01;
				default:   shift_reg <= shift_reg;
			endcase
		end
	end

	// Memory selection follows the last address-setting instruction
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			sel_cg_reg <= 1'b0;
		else if (exec_done)
		begin
			unique case (op_reg)
				OP_SET_CG: sel_cg_reg <= 1'b1;
				OP_SET_DD, OP_CLEAR, OP_HOME: sel_cg_reg <= 1'b0;
				OP_SHIFT:  if (!cmd_reg[`CLCD_SHIFT_SC_BIT]) sel_cg_reg <= 1'b0;
				default:   sel_cg_reg <= sel_cg_reg;
			endcase
		end
	end

	// Mode flags
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			flags_reg <= '{`CLCD_RST_DISP_ON, `CLCD_RST_CURSOR_ON, `CLCD_RST_BLINK_ON,
				`CLCD_RST_INCR, `CLCD_RST_SHIFT_ON, `CLCD_RST_BUS8,
				`CLCD_RST_TWO_LINE, `CLCD_RST_FONT10};
		else if (por_done)
			flags_reg <= '{`CLCD_RST_DISP_ON, `CLCD_RST_CURSOR_ON, `CLCD_RST_BLINK_ON,
				`CLCD_RST_INCR, `CLCD_RST_SHIFT_ON, `CLCD_RST_BUS8,
				`CLCD_RST_TWO_LINE, `CLCD_RST_FONT10};
		else if (exec_done)
		begin
			unique case (op_reg)
				OP_CLEAR:   flags_reg.incr <= 1'b1;
				OP_ENTRY:
				begin
					flags_reg.incr     <= cmd_reg[`CLCD_ENTRY_INCR_BIT];
					flags_reg.shift_on <= cmd_reg[`CLCD_ENTRY_SHIFT_BIT];
				end
				OP_DISPCTL:
				begin
					flags_reg.display_on <= cmd_reg[`CLCD_DISP_ON_BIT];
					flags_reg.cursor_on  <= cmd_reg[`CLCD_DISP_CUR_BIT];
					flags_reg.blink_on   <= cmd_reg[`CLCD_DISP_BLINK_BIT];
				end
				OP_FUNC:
				begin
					flags_reg.bus8     <= cmd_reg[`CLCD_FUNC_DL_BIT];
					flags_reg.two_line <= cmd_reg[`CLCD_FUNC_N_BIT];
					flags_reg.font10   <= cmd_reg[`CLCD_FUNC_F_BIT];
				end
				default:    flags_reg <= flags_reg;
			endcase
		end
	end

	// Fill walk over display memory during power-on and clear
	assign fill_active = !fill_reg[7];
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			fill_reg <= 8'h80;
		else if (por_start_reg || (instr_go && decode_instr(host_byte) == OP_CLEAR))
			fill_reg <= 8'h00;
		else if (fill_active)
			fill_reg <= fill_reg + 8'h01;
	end

	// Memory write ports
	assign dd_we    = fill_active || (exec_done && op_reg == OP_DWRITE && !sel_cg_reg);
	assign dd_waddr = fill_active ? fill_reg[6:0] : ac_reg;
	assign dd_wdata = fill_active ? `CLCD_FILL_CODE : cmd_reg;
	assign cg_we    = exec_done && op_reg == OP_DWRITE && sel_cg_reg;

	clcd_mem #(.P_DEPTH(`CLCD_DD_DEPTH), .P_AW(7)) u_dd_mem (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_we      (dd_we),
		.i_waddr   (dd_waddr),
		.i_wdata   (dd_wdata),
		.i_raddr   (ac_reg),
		.o_rdata   (dd_rdata)
	);

	clcd_mem #(.P_DEPTH(`CLCD_CG_DEPTH), .P_AW(6)) u_cg_mem (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_we      (cg_we),
		.i_waddr   (ac_reg[5:0]),
		.i_wdata   (cmd_reg),
		.i_raddr   (ac_reg[5:0]),
		.o_rdata   (cg_rdata)
	);

	// Read data selection
	assign rd_byte = is_instr ? {busy_reg, ac_reg}
		: (sel_cg_reg ? cg_rdata : dd_rdata);
	assign rd_lane = flags_reg.bus8 ? rd_byte
		: (nib_phase_reg ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[`CLCD_ST_FLAGS_LSB +: 8] = flags_reg;
		status_word[`CLCD_ST_SELCG_BIT]      = sel_cg_reg;
		status_word[`CLCD_ST_BUSY_BIT]       = busy_reg;
		status_word[`CLCD_ST_PEND_BIT]       = step_pend_reg;
		status_word[`CLCD_ST_SHIFT_LSB +: 7] = shift_reg;
		status_word[`CLCD_ST_AC_LSB +: 7]    = ac_reg;
	end
	assign rd_word = is_status ? status_word : {24'h00_0000, rd_lane};

	// APB answer; data reads take one wait state for the memory read
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end
		else if (setup || (i_psel && i_penable && !pready_reg))
		begin
			pready_reg  <= !(setup && is_data && !i_pwrite);
			pslverr_reg <= err;
			prdata_reg  <= i_pwrite ? 32'h0000_0000 : rd_word;
		end
		else
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign o_pready       = pready_reg;
	assign o_pslverr      = pslverr_reg;
	assign o_prdata       = prdata_reg;
	assign o_busy         = busy_reg;
	assign o_addr_counter = ac_reg;
	assign o_disp_shift   = shift_reg;
	assign o_sel_glyph    = sel_cg_reg;
	assign o_flags        = flags_reg;
endmodule : clcd_unit

/* File: clcd_unit_props.sv */
// Port checks of the LCD instruction unit, bound to its top
`timescale 1ns/1ps
module clcd_unit_props #(
	parameter int P_OSC_KHZ   = 250,
	parameter int P_CLEAR_CYC = 200
) (
	input wire logic                  i_sys_clk,
	input wire logic                  i_reset_n,
	input wire logic                  i_psel,
	input wire logic                  i_penable,
	input wire logic                  i_pwrite,
	input wire logic [7:0]            i_paddr,
	input wire logic                  o_pready,
	input wire logic                  o_pslverr,
	input wire logic                  o_busy,
	input wire logic [6:0]            o_addr_counter,
	input wire clcd_pkg::clcd_flags_s o_flags
);
	import clcd_pkg::*;
	localparam int L_EXEC = 40 * 100 * 250 / P_OSC_KHZ;
	int   busy_cnt;
	logic por_done;

	// Length of the current busy spell
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
		if (!i_reset_n)
			busy_cnt <= 0;
		else
			busy_cnt <= o_busy ? busy_cnt + 1 : 0;

	// Power-on busy spell has its own length
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
		if (!i_reset_n)
			por_done <= 1'b0;
		else if (!o_busy)
			por_done <= 1'b1;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	ready_wait_a: assert property (i_psel && !i_penable |-> ##[1:2] o_pready)
		else $error("transfer not answered");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("pready held");
	err_ready_a: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
		else $error("pslverr outside answer");
	busy_refuse_a: assert property (o_pready && o_busy &&
		(i_paddr == 8'h04 || i_pwrite && i_paddr == 8'h00) |-> o_pslverr)
		else $error("access taken while busy");
	unmapped_a: assert property (o_pready &&
		!(i_paddr inside {8'h00, 8'h04, 8'h08}) |-> o_pslverr)
		else $error("unmapped access taken");
	busy_start_a: assert property (o_pready && !o_pslverr && o_flags.bus8 &&
		(i_paddr == 8'h04 || i_pwrite && i_paddr == 8'h00) |=> o_busy)
		else $error("busy not raised");
	ac_frozen_a: assert property (o_busy && $past(o_busy) |-> $stable(o_addr_counter))
		else $error("counter moved while busy");
	busy_len_a: assert property ($fell(o_busy) && por_done |->
		busy_cnt inside {[L_EXEC-2:L_EXEC+2], [P_CLEAR_CYC-2:P_CLEAR_CYC+2]})
		else $error("wrong execution length");
endmodule : clcd_unit_props

bind clcd_unit clcd_unit_props #(.P_OSC_KHZ(P_OSC_KHZ), .P_CLEAR_CYC(P_CLEAR_CYC))
	clcd_unit_props_i (
	.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy),
	.o_addr_counter(o_addr_counter), .o_flags(o_flags)
);

/* File: tb.sv */
// Self-checking bench of the LCD instruction unit
`timescale 1ns/1ps
module tb;
	import clcd_pkg::*;
	localparam int L_OSC = 1000;
	localparam int L_ADD = 6 * 100 * 250 / L_OSC;
	logic        i_sys_clk, i_reset_n, psel, penable, pwrite, pready, pslverr, e, selg;
	logic [6:0]  dshift;
	logic [7:0]  paddr, fe, b, a, d;
	logic [31:0] pwdata, prdata, s, r;
	logic [7:0]  init_q [4] = '{8'h01, 8'h30, 8'h08, 8'h06};
	int          miscompares, n_checks;

	clcd_unit #(.P_OSC_KHZ(L_OSC), .P_CLEAR_CYC(200), .P_POR_CYC(200)) clcd_unit_i (
		.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_busy(),
		.o_addr_counter(), .o_disp_shift(dshift), .o_sel_glyph(selg), .o_flags()
	);
	clcd_host clcd_host_i (
		.i_sys_clk(i_sys_clk), .i_prdata(prdata), .i_pready(pready),
		.i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
		.o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
	);

	// Clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// Expected mode flags after an instruction byte
	function automatic logic [7:0] nf(input logic [7:0] f, input logic [7:0] v);
		if (v[7:3] == 5'h01)
			f[7:5] = v[2:0];
		else if (v[7:2] == 6'h01)
			f[4:3] = v[1:0];
		else if (v[7:5] == 3'h1)
			f[2:0] = v[4:2];
		return f;
	endfunction : nf

	task automatic ins(input logic [7:0] v);
		clcd_host_i.xfer(1'b1, 8'h00, {24'h0, v}, r, e);
		check("instr taken", e, 1'b0);
		clcd_host_i.wait_idle();
	endtask : ins

	task automatic dat(input logic w, input logic [7:0] v);
		clcd_host_i.xfer(w, 8'h04, {24'h0, v}, r, e);
		clcd_host_i.wait_idle();
	endtask : dat

	task automatic st();
		clcd_host_i.xfer(1'b0, 8'h08, 32'h0, s, e);
	endtask : st

	// Main sequence
	initial
	begin
		i_reset_n = 1'b0;
		miscompares = 0;
		n_checks = 0;
		void'($urandom(32'h6C0B9C88));
		repeat (4) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		st();
		check("por state", {s[9], s[7:0]}, 9'h114);
		clcd_host_i.xfer(1'b1, 8'h00, 32'h0C, r, e);
		check("busy refused", e, 1'b1);
		clcd_host_i.xfer(1'b0, 8'h00, 32'h0, r, e);
		check("status read", {e, r[7:0]}, 9'h080);
		clcd_host_i.wait_idle();
		ins(8'h85);
		dat(1'b0, 8'h00);
		check("fill code", r[7:0], 8'h20);
		foreach (init_q[i])
			ins(init_q[i]);
		fe = 8'h14;
		for (int i = 0; i < 6; i++)
		begin
			d = $urandom;
			b = (i % 3 == 0) ? {6'h01, d[1:0]} :
				(i % 3 == 1) ? {5'h01, d[2:0]} : {4'h3, d[3:0]};
			ins(b);
			fe = nf(fe, b);
			st();
			check("mode flags", s[7:0], fe);
		end
		ins(8'h06);
		a = $urandom % 100;
		d = $urandom;
		ins({1'b1, a[6:0]});
		clcd_host_i.xfer(1'b1, 8'h04, {24'h0, d}, r, e);
		st();
		check("ac before", {s[9], s[30:24]}, {1'b1, a[6:0]});
		clcd_host_i.wait_idle();
		st();
		check("step waits", {s[10], s[30:24]}, {1'b1, a[6:0]});
		repeat (L_ADD + 4) @(posedge i_sys_clk);
		st();
		check("step done", {s[10], s[30:24]}, {1'b0, a[6:0] + 7'h01});
		ins({1'b1, a[6:0]});
		dat(1'b0, 8'h00);
		check("read back", r[7:0], d);
		ins({2'b01, d[5:0]});
		st();
		check("glyph addr", {s[8], s[30:24]}, {2'b10, d[5:0]});
		check("glyph port", selg, 1'b1);
		dat(1'b1, d ^ 8'h5A);
		ins({2'b01, d[5:0]});
		dat(1'b0, 8'h00);
		check("glyph data", r[7:0], d ^ 8'h5A);
		ins(8'h85);
		ins(8'h14);
		ins(8'h18);
		st();
		check("shifts", {s[30:24], s[22:16], s[8]}, {7'h06, 7'h01, 1'b0});
		check("shift port", {dshift, selg}, {7'h01, 1'b0});
		ins(8'h02);
		st();
		check("home", {s[30:24], s[22:16]}, 14'h0);
		ins(8'h07);
		dat(1'b1, d);
		st();
		check("shift on write", s[22:16], 7'h01);
		ins(8'h05);
		dat(1'b1, d);
		repeat (L_ADD + 4) @(posedge i_sys_clk);
		st();
		check("decrement", {s[30:24], s[22:16], dshift}, 21'h0);
		ins(8'h01);
		st();
		check("clear", {s[30:24], s[22:16], s[4:3]}, {14'h0, 2'b11});
		ins(8'h80);
		dat(1'b0, 8'h00);
		check("cleared", r[7:0], 8'h20);
		ins(8'h20);
		clcd_host_i.xfer(1'b1, 8'h00, 32'h00, r, e);
		st();
		check("half byte", {s[9], s[2]}, 2'b00);
		clcd_host_i.xfer(1'b1, 8'h00, 32'hF0, r, e);
		clcd_host_i.wait_idle();
		st();
		check("nibble instr", {s[7:5], s[2]}, 4'hE);
		clcd_host_i.xfer(1'b0, 8'h00, 32'h0, s, e);
		clcd_host_i.xfer(1'b0, 8'h00, 32'h0, r, e);
		check("nibble status", {s[7:4], r[7:4]}, 8'h01);
		clcd_host_i.xfer(1'b1, 8'h00, 32'h30, r, e);
		clcd_host_i.xfer(1'b1, 8'h00, 32'h00, r, e);
		clcd_host_i.wait_idle();
		st();
		check("byte bus", s[2], 1'b1);
		clcd_host_i.xfer(1'b0, 8'h0C, 32'h0, r, e);
		check("unmapped", e, 1'b1);
		clcd_host_i.xfer(1'b1, 8'h08, 32'h0, r, e);
		check("status write", e, 1'b1);
		clcd_host_i.xfer(1'b1, 8'h00, 32'h08, r, e);
		clcd_host_i.xfer(1'b1, 8'h04, 32'h41, r, e);
		check("data while busy", e, 1'b1);
		clcd_host_i.wait_idle();
		i_reset_n <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		st();
		check("reset again", {s[9], s[7:0], dshift}, {9'h114, 7'h00});
		clcd_host_i.wait_idle();
		end_sim();
	end
endmodule : tb
